// [hdl/irtcr_pkg.sv]
package irtcr_pkg;

  // configuration field positions
  localparam int unsigned CFG_IIR_LSB = 0;
  localparam int unsigned CFG_IIR_MSB = 2;
  localparam int unsigned CFG_AMB_SEL_BIT = 3;
  localparam int unsigned CFG_PWM_DATA_LSB = 4;
  localparam int unsigned CFG_PWM_DATA_MSB = 5;
  localparam int unsigned CFG_TWO_IR_BIT = 6;
  localparam int unsigned CFG_KS_BIT = 7;
  localparam int unsigned CFG_FIR_LSB = 8;
  localparam int unsigned CFG_FIR_MSB = 10;
  localparam int unsigned CFG_GAIN_LSB = 11;
  localparam int unsigned CFG_GAIN_MSB = 13;
  localparam int unsigned CFG_UNUSED_BIT = 14;
  localparam int unsigned CFG_SHOCK_BIT = 15;

  // command byte opcodes and addresses
  localparam logic [2:0] OPC_RESULT = 3'h0;
  localparam logic [2:0] OPC_NVM = 3'h1;
  localparam logic [4:0] NVM_CFG_ADDR = 5'h05;
  localparam logic [4:0] RES_AMB_ADDR = 5'h06;
  localparam logic [4:0] RES_OBJ1_ADDR = 5'h07;
  localparam logic [4:0] RES_OBJ2_ADDR = 5'h08;
  localparam int unsigned RES_WORDS = 32;
  localparam int unsigned RES_WIDTH = 17;

  // configuration reset value (arbitrary neutral default)
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // iir coefficients in q1.15
  localparam logic [15:0] Q_HALF = 16'h4000;
  localparam logic [15:0] Q_4_7 = 16'h4925;
  localparam logic [15:0] Q_3_7 = 16'h36DB;
  localparam logic [15:0] Q_2_3 = 16'h5555;
  localparam logic [15:0] Q_1_3 = 16'h2AAB;
  localparam logic [15:0] Q_0_8 = 16'h6666;
  localparam logic [15:0] Q_0_2 = 16'h1999;
  localparam logic [15:0] Q_ONE = 16'h7FFF;
  localparam logic [15:0] Q_ZERO = 16'h0000;

  // gain in tenths
  localparam logic [10:0] GAIN_1 = 11'h00A;
  localparam logic [10:0] GAIN_3 = 11'h01E;
  localparam logic [10:0] GAIN_6 = 11'h03C;
  localparam logic [10:0] GAIN_12P5 = 11'h07D;
  localparam logic [10:0] GAIN_25 = 11'h0FA;
  localparam logic [10:0] GAIN_50 = 11'h1F4;
  localparam logic [10:0] GAIN_100 = 11'h3E8;

  typedef enum logic [3:0] {
    PWM_SRC_AMBIENT = 4'h1,
    PWM_SRC_IR_ONE = 4'h2,
    PWM_SRC_IR_TWO = 4'h4,
    PWM_SRC_UNDEF = 4'h8
  } irtcr_pwm_src_t;

  typedef struct packed {
    logic [15:0] iir_a1;
    logic [15:0] iir_b1;
    logic iir_bypass;
    logic ambient_ptc;
    irtcr_pwm_src_t pwm_first;
    irtcr_pwm_src_t pwm_second;
    logic two_ir;
    logic emissivity_slope_sign;
    logic [10:0] fir_len;
    logic [10:0] gain_x10;
    logic preamp_bypass;
    logic shock_negative;
  } irtcr_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [4:0] addr;
    logic [RES_WIDTH-1:0] data;
  } irtcr_wr_t;

endpackage : irtcr_pkg

// [hdl/irtcr_regs.sv]
`timescale 1ns/10ps
// Function
// - bits 2..0 pick iir coefficient pair; code 100 bypasses the filter
// - bit 3 picks ambient sensor type, one ptc, zero ptat
// - bits 5..4 pick the two values carried on the pwm output
// - bit 6 enables two infrared sensors, else one
// - bits 10..8 set averaging length 8 up to 1024 samples
// - bits 13..11 set amplifier gain 1 to 100, bypass at code 000
// - bit 15 gives thermoshock compensation sign, one negative; bit 14 unused
// - writes to result memory from the bus are ignored
// - all 32 result words of 17 bits readable; 6,7,8 are temperatures
// - command 000 plus address reads results, 001 reaches nonvolatile cells
// - msb of linearized temperature words is an active-high error flag
module irtcr_regs
  import irtcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_i,
  input wire logic cmd_write_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic [RES_WIDTH-1:0] cmd_nvm_rdata_i,
  input wire irtcr_wr_t meas_wr_i,
  output logic rd_valid_o,
  output logic [RES_WIDTH-1:0] rd_data_o,
  output logic rd_temp_error_o,
  output logic [15:0] cfg_o,
  output irtcr_ctrl_t ctrl_o
);

  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [RES_WIDTH-1:0] res_q [RES_WORDS];
  logic [RES_WIDTH-1:0] res_d [RES_WORDS];
  logic rd_valid_q;
  logic rd_valid_d;
  logic [RES_WIDTH-1:0] rd_data_q;
  logic [RES_WIDTH-1:0] rd_data_d;
  logic rd_err_q;
  logic rd_err_d;
  logic [15:0] iir_a1_q;
  logic [15:0] iir_a1_d;
  logic [15:0] iir_b1_q;
  logic [15:0] iir_b1_d;
  logic iir_bypass_q;
  logic iir_bypass_d;
  logic ambient_ptc_q;
  logic ambient_ptc_d;
  logic two_ir_q;
  logic two_ir_d;
  logic slope_sign_q;
  logic slope_sign_d;
  logic shock_negative_q;
  logic shock_negative_d;
  irtcr_pwm_src_t pwm_first_q;
  irtcr_pwm_src_t pwm_first_d;
  irtcr_pwm_src_t pwm_second_q;
  irtcr_pwm_src_t pwm_second_d;
  logic [10:0] fir_len_q;
  logic [10:0] fir_len_d;
  logic [10:0] gain_x10_q;
  logic [10:0] gain_x10_d;
  logic preamp_bypass_q;
  logic preamp_bypass_d;
  logic [2:0] iir_code;
  logic [1:0] pwm_code;
  logic [2:0] fir_code;
  logic [2:0] gain_code;
  logic [2:0] opc;
  logic [4:0] addr;

  assign opc = cmd_i[7:5];
  assign addr = cmd_i[4:0];

  // configuration word, written through the nonvolatile command
  always_comb begin
    cfg_d = cfg_q;
    if (cmd_valid_i && cmd_write_i && opc == OPC_NVM &&
        addr == NVM_CFG_ADDR) begin
      cfg_d = cmd_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_q <= CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // result memory: only measurement processing updates it
  generate
    for (genvar i = 0; i < RES_WORDS; i++) begin : g_res
      always_comb begin
        res_d[i] = res_q[i];
        if (meas_wr_i.valid && meas_wr_i.addr == 5'(i)) begin
          res_d[i] = meas_wr_i.data;
        end
      end
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          res_q[i] <= '0;
        end else begin
          res_q[i] <= res_d[i];
        end
      end
    end
  endgenerate

  // read path
  always_comb begin
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    rd_err_d = rd_err_q;
    if (cmd_valid_i && !cmd_write_i) begin
      if (opc == OPC_RESULT) begin
        rd_valid_d = 1'b1;
        rd_data_d = res_q[addr];
        rd_err_d = (addr == RES_AMB_ADDR || addr == RES_OBJ1_ADDR ||
                    addr == RES_OBJ2_ADDR) &&
                   res_q[addr][RES_WIDTH-1];
      end else if (opc == OPC_NVM) begin
        rd_valid_d = 1'b1;
        rd_data_d = (addr == NVM_CFG_ADDR) ? {1'b0, cfg_q} :
                    cmd_nvm_rdata_i;
        rd_err_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
      rd_err_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
      rd_err_q <= rd_err_d;
    end
  end

  // configuration fields feeding the decode groups
  assign iir_code = cfg_q[CFG_IIR_MSB:CFG_IIR_LSB];
  assign pwm_code = cfg_q[CFG_PWM_DATA_MSB:CFG_PWM_DATA_LSB];
  assign fir_code = cfg_q[CFG_FIR_MSB:CFG_FIR_LSB];
  assign gain_code = cfg_q[CFG_GAIN_MSB:CFG_GAIN_LSB];

  // iir coefficient group
  always_comb begin
    iir_a1_d = Q_HALF;
    iir_b1_d = Q_HALF;
    iir_bypass_d = 1'h0;
    case (iir_code)
      3'h7: begin
        iir_a1_d = Q_4_7;
        iir_b1_d = Q_3_7;
      end
      3'h6: begin
        iir_a1_d = Q_2_3;
        iir_b1_d = Q_1_3;
      end
      3'h5: begin
        iir_a1_d = Q_0_8;
        iir_b1_d = Q_0_2;
      end
      3'h4: begin
        iir_a1_d = Q_ONE;
        iir_b1_d = Q_ZERO;
        iir_bypass_d = 1'h1;
      end
      default: begin
        iir_a1_d = Q_HALF;
        iir_b1_d = Q_HALF;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      iir_a1_q <= 16'h0000;
      iir_b1_q <= 16'h0000;
      iir_bypass_q <= 1'h0;
    end else begin
      iir_a1_q <= iir_a1_d;
      iir_b1_q <= iir_b1_d;
      iir_bypass_q <= iir_bypass_d;
    end
  end

  // single-bit sensor and compensation selects
  always_comb begin
    ambient_ptc_d = cfg_q[CFG_AMB_SEL_BIT];
    two_ir_d = cfg_q[CFG_TWO_IR_BIT];
    slope_sign_d = cfg_q[CFG_KS_BIT];
    shock_negative_d = cfg_q[CFG_SHOCK_BIT];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ambient_ptc_q <= 1'h0;
      two_ir_q <= 1'h0;
      slope_sign_q <= 1'h0;
      shock_negative_q <= 1'h0;
    end else begin
      ambient_ptc_q <= ambient_ptc_d;
      two_ir_q <= two_ir_d;
      slope_sign_q <= slope_sign_d;
      shock_negative_q <= shock_negative_d;
    end
  end

  // pwm data source pair
  always_comb begin
    pwm_first_d = PWM_SRC_IR_TWO;
    pwm_second_d = PWM_SRC_UNDEF;
    case (pwm_code)
      2'h0: begin
        pwm_first_d = PWM_SRC_AMBIENT;
        pwm_second_d = PWM_SRC_IR_ONE;
      end
      2'h1: begin
        pwm_first_d = PWM_SRC_AMBIENT;
        pwm_second_d = PWM_SRC_IR_TWO;
      end
      2'h3: begin
        pwm_first_d = PWM_SRC_IR_ONE;
        pwm_second_d = PWM_SRC_IR_TWO;
      end
      default: begin
        pwm_first_d = PWM_SRC_IR_TWO;
        pwm_second_d = PWM_SRC_UNDEF;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_first_q <= irtcr_pwm_src_t'(4'h0);
      pwm_second_q <= irtcr_pwm_src_t'(4'h0);
    end else begin
      pwm_first_q <= pwm_first_d;
      pwm_second_q <= pwm_second_d;
    end
  end

  // averaging length doubles with each code step
  always_comb begin
    fir_len_d = 11'h008 << fir_code;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fir_len_q <= 11'h000;
    end else begin
      fir_len_q <= fir_len_d;
    end
  end

  // amplifier gain; code 000 bypasses the preamplifier
  always_comb begin
    gain_x10_d = GAIN_100;
    preamp_bypass_d = 1'h0;
    case (gain_code)
      3'h0: begin
        gain_x10_d = GAIN_1;
        preamp_bypass_d = 1'h1;
      end
      3'h1: begin
        gain_x10_d = GAIN_3;
      end
      3'h2: begin
        gain_x10_d = GAIN_6;
      end
      3'h3: begin
        gain_x10_d = GAIN_12P5;
      end
      3'h4: begin
        gain_x10_d = GAIN_25;
      end
      3'h5: begin
        gain_x10_d = GAIN_50;
      end
      default: begin
        gain_x10_d = GAIN_100;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gain_x10_q <= 11'h000;
      preamp_bypass_q <= 1'h0;
    end else begin
      gain_x10_q <= gain_x10_d;
      preamp_bypass_q <= preamp_bypass_d;
    end
  end

  assign rd_valid_o = rd_valid_q;
  assign rd_data_o = rd_data_q;
  assign rd_temp_error_o = rd_err_q;
  assign cfg_o = cfg_q;
  assign ctrl_o = '{
    iir_a1: iir_a1_q,
    iir_b1: iir_b1_q,
    iir_bypass: iir_bypass_q,
    ambient_ptc: ambient_ptc_q,
    pwm_first: pwm_first_q,
    pwm_second: pwm_second_q,
    two_ir: two_ir_q,
    emissivity_slope_sign: slope_sign_q,
    fir_len: fir_len_q,
    gain_x10: gain_x10_q,
    preamp_bypass: preamp_bypass_q,
    shock_negative: shock_negative_q
  };

endmodule : irtcr_regs

// [verification/irtcr_host.sv]
`timescale 1ns/10ps
// host keeps calibration bits and no extended pwm exists here
module irtcr_host (
  input wire logic clk_i,
  output logic cmd_valid_o,
  output logic [7:0] cmd_o,
  output logic cmd_write_o,
  output logic [15:0] cmd_wdata_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = 8'hFF;
    cmd_write_o = 1'b0;
    cmd_wdata_o = 16'h0000;
  end
  // opcode in top bits, address in low five
  task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_o = c;
    cmd_write_o = w;
    cmd_wdata_o = d;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_o = ~c;
    cmd_wdata_o = ~d;
  endtask : xfer
endmodule : irtcr_host

// [verification/irtcr_regs_sva.sv]
`timescale 1ns/10ps
module irtcr_regs_sva
  import irtcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_i,
  input wire logic cmd_write_i,
  input wire logic rd_valid_o,
  input wire logic [RES_WIDTH-1:0] rd_data_o,
  input wire logic rd_temp_error_o,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic [15:0] cfg_o,
  input wire irtcr_ctrl_t ctrl_o
);
  logic [15:0] cfg_p_q;
  always_ff @(posedge clk_i) cfg_p_q <= cfg_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_rd;
    cmd_valid_i && !cmd_write_i && cmd_i[7:6] == 2'b00;
  endsequence
  sequence s_cfg;
    cmd_valid_i && cmd_write_i && cmd_i == 8'h25;
  endsequence
  read_answer_a: assert property (s_rd |=> rd_valid_o)
    else $error("read left unanswered");
  no_spur_a: assert property (!(cmd_valid_i && !cmd_write_i
    && cmd_i[7:6] == 2'b00) |=> !rd_valid_o)
    else $error("answer without read");
  err_msb_a: assert property (rd_temp_error_o |-> rd_data_o[16])
    else $error("error flag without msb");
  err_nvm_a: assert property (s_rd ##0 cmd_i[5] |=> !rd_temp_error_o)
    else $error("error flag on nvm read");
  cfg_write_a: assert property (s_cfg |=> cfg_o == $past(cmd_wdata_i))
    else $error("config not stored");
  cfg_hold_a: assert property (!(cmd_valid_i && cmd_write_i
    && cmd_i == 8'h25) |=> $stable(cfg_o))
    else $error("config changed unasked");
  fir_len_a: assert property ($past(rst_b_i) |->
    ctrl_o.fir_len == 11'h008 << cfg_p_q[10:8])
    else $error("averaging length wrong");
  ctrl_bits_a: assert property ($past(rst_b_i) |->
    {ctrl_o.ambient_ptc, ctrl_o.two_ir, ctrl_o.shock_negative,
    ctrl_o.emissivity_slope_sign} == {cfg_p_q[3], cfg_p_q[6],
    cfg_p_q[15], cfg_p_q[7]})
    else $error("control bit decode wrong");
  bypass_a: assert property ($past(rst_b_i) |->
    ctrl_o.iir_bypass == (cfg_p_q[2:0] == 3'h4) &&
    ctrl_o.preamp_bypass == (cfg_p_q[13:11] == 3'h0))
    else $error("bypass decode wrong");
endmodule : irtcr_regs_sva
bind irtcr_regs irtcr_regs_sva u_sva (.clk_i, .rst_b_i, .cmd_valid_i,
  .cmd_i, .cmd_write_i, .rd_valid_o, .rd_data_o, .rd_temp_error_o,
  .cmd_wdata_i, .cfg_o, .ctrl_o);

// [verification/ir_thermometer_config_result_regs_test.sv]
`timescale 1ns/10ps
module ir_thermometer_config_result_regs_test;
  import irtcr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cmd_valid_i, cmd_write_i, rd_valid_o, rd_temp_error_o;
  logic [7:0] cmd_i;
  logic [15:0] cmd_wdata_i, cfg_o, w;
  logic [RES_WIDTH-1:0] nvm_q = 17'h00000;
  logic [RES_WIDTH-1:0] rd_data_o;
  logic [RES_WIDTH-1:0] mem[32];
  irtcr_wr_t meas_wr_i = '0;
  irtcr_ctrl_t ctrl_o;
  logic [17:0] exp_q[$];
  logic [31:0] seed = 32'hD1969EB6;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  logic [10:0] gain_t[8] = '{GAIN_1, GAIN_3, GAIN_6, GAIN_12P5, GAIN_25,
    GAIN_50, GAIN_100, GAIN_100};
  logic [15:0] a1_t[8] = '{Q_HALF, Q_HALF, Q_HALF, Q_HALF, Q_ONE, Q_0_8,
    Q_2_3, Q_4_7};
  irtcr_pwm_src_t p1_t[4] = '{PWM_SRC_AMBIENT, PWM_SRC_AMBIENT,
    PWM_SRC_IR_TWO, PWM_SRC_IR_ONE};
  logic [15:0] b1_t[8] = '{Q_HALF, Q_HALF, Q_HALF, Q_HALF, Q_ZERO, Q_0_2,
    Q_1_3, Q_3_7};
  irtcr_pwm_src_t p2_t[4] = '{PWM_SRC_IR_ONE, PWM_SRC_IR_TWO,
    PWM_SRC_UNDEF, PWM_SRC_IR_TWO};
  always #2 clk_i = ~clk_i;
  irtcr_regs u_irtcr_regs (.clk_i, .rst_b_i, .cmd_valid_i, .cmd_i,
    .cmd_write_i, .cmd_wdata_i, .cmd_nvm_rdata_i(nvm_q), .meas_wr_i,
    .rd_valid_o, .rd_data_o, .rd_temp_error_o, .cfg_o, .ctrl_o);
  irtcr_host u_irtcr_host (.clk_i, .cmd_valid_o(cmd_valid_i),
    .cmd_o(cmd_i), .cmd_write_o(cmd_write_i), .cmd_wdata_o(cmd_wdata_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic results();
    $display("miscompares %0d samples_checked %0d", miscompares,
      samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] c, input logic [16:0] d);
    exp_q.push_back({c[7:5] == OPC_RESULT && c[4:0] inside {[6:8]}
      && d[16], d});
    u_irtcr_host.xfer(c, 1'b0, 16'h0000);
  endtask : rd
  task automatic mw(input logic [4:0] a, input logic [16:0] d);
    @(negedge clk_i);
    meas_wr_i = '{1'b1, a, d};
    mem[a] = d;
    @(negedge clk_i);
    meas_wr_i.valid = 1'b0;
  endtask : mw
  // answers compared in issue order
  always @(negedge clk_i) begin
    cycles++;
    if (cycles > 3000) begin
      miscompares++;
      results();
    end
    if (rd_valid_o === 1'b1) chk({rd_temp_error_o, rd_data_o},
      exp_q.pop_front());
  end
  initial begin
    repeat (4) @(negedge clk_i);
    rst_b_i = 1'b1;
    rd(8'h25, 17'h00000);
    for (int i = 0; i < 32; i++) mw(i[4:0], 17'(rnd()));
    for (int i = 0; i < 32; i++) rd({OPC_RESULT, i[4:0]}, mem[i]);
    u_irtcr_host.xfer({OPC_RESULT, 5'h07}, 1'b1, 16'hFFFF);
    rd({OPC_RESULT, 5'h07}, mem[7]);
    nvm_q = 17'(rnd());
    rd(8'h3C, nvm_q);
    u_irtcr_host.xfer(8'hF0, 1'b0, 16'h0000);
    u_irtcr_host.xfer(8'h2E, 1'b1, 16'hFFFF);
    rd(8'h25, 17'h00000);
    for (int c = 0; c < 8; c++) begin
      w = {c[1], ~c[2], c[2:0], c[2:0], c[2], ~c[0], c[1:0], c[0], c[2:0]};
      u_irtcr_host.xfer(8'h25, 1'b1, w);
      rd(8'h25, {1'b0, w});
      chk(18'(cfg_o), 18'(w));
      chk(18'(ctrl_o.fir_len), 18'(11'h008 << c));
      chk(18'(ctrl_o.gain_x10), 18'(gain_t[c]));
      chk(18'(ctrl_o.iir_a1), 18'(a1_t[c]));
      chk(18'(ctrl_o.iir_b1), 18'(b1_t[c]));
      chk(18'(ctrl_o.pwm_first), 18'(p1_t[c[1:0]]));
      chk(18'(ctrl_o.pwm_second), 18'(p2_t[c[1:0]]));
      chk(18'({ctrl_o.ambient_ptc, ctrl_o.two_ir,
        ctrl_o.shock_negative, ctrl_o.emissivity_slope_sign,
        ctrl_o.iir_bypass, ctrl_o.preamp_bypass}), 18'({c[0], ~c[0],
        c[1], c[2], c == 4, c == 0}));
    end
    @(negedge clk_i);
    rst_b_i = 1'b0;
    @(negedge clk_i);
    rst_b_i = 1'b1;
    chk(18'({cfg_o, rd_valid_o}), 18'h00000);
    rd({OPC_RESULT, RES_AMB_ADDR}, 17'h00000);
    repeat (3) @(negedge clk_i);
    chk(18'(exp_q.size()), 18'h00000);
    results();
  end
endmodule : ir_thermometer_config_result_regs_test
